/* File: rtl/rom_io_port.sv */
// Host bus side of a 2048x8 ROM with two 8-bit I/O ports
`timescale 1ns/1ps
module rom_io_port
  import rom_port_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic CLK_EN,
  input wire logic RESET,
  input wire logic ADDR_STROBE,
  input wire logic [DATA_W-1:0] MUXED_BUS_LINES_IN,
  output logic [DATA_W-1:0] MUXED_BUS_LINES_OUT,
  output logic MUXED_BUS_LINES_OE,
  input wire logic [UPPER_W-1:0] UPPER_ROM_LINES,
  input wire logic IO_SPACE,
  input wire logic ENABLE_LOW_INPUT_B,
  input wire logic ENABLE_HIGH_INPUT,
  input wire logic MEM_READ_STROBE_B,
  input wire logic PORT_READ_STROBE_B,
  input wire logic PORT_WRITE_STROBE_B,
  output logic WAIT_OUT,
  output logic WAIT_OE,
  input wire logic [DATA_W-1:0] FIRST_PORT_PINS_IN,
  output logic [DATA_W-1:0] FIRST_PORT_PINS_OUT,
  output logic [DATA_W-1:0] FIRST_PORT_PINS_OE,
  input wire logic [DATA_W-1:0] SECOND_PORT_PINS_IN,
  output logic [DATA_W-1:0] SECOND_PORT_PINS_OUT,
  output logic [DATA_W-1:0] SECOND_PORT_PINS_OE
);
  // Address latch state
  logic strobe_d;
  logic [DATA_W-1:0] low_addr;
  logic [UPPER_W-1:0] upper_addr;
  logic io_latched;
  logic selected;
  logic next_strobe_d;
  logic [DATA_W-1:0] next_low_addr;
  logic [UPPER_W-1:0] next_upper_addr;
  logic next_io_latched;
  logic next_selected;

  // Strobe history for write release
  logic write_d;
  logic next_write_d;

  // Wait line state
  logic wait_active;
  logic next_wait_active;

  // Read data register
  logic [DATA_W-1:0] read_data;
  logic [DATA_W-1:0] next_read_data;
  logic drive_bus;
  logic next_drive_bus;

  logic strobe_fall;
  logic [SEL_W-1:0] sel;
  logic io_read;
  logic mem_read;
  logic write_now;
  logic write_release;
  logic [DATA_W-1:0] rom_data;
  logic [DATA_W-1:0] first_read;
  logic [DATA_W-1:0] second_read;
  logic [DATA_W-1:0] port_read;
  logic enables_live;

  assign strobe_fall = strobe_d & ~ADDR_STROBE;
  assign sel = low_addr[SEL_W-1:0];
  assign enables_live = ~ENABLE_LOW_INPUT_B & ENABLE_HIGH_INPUT;
  assign io_read = selected & (~PORT_READ_STROBE_B | (~MEM_READ_STROBE_B & io_latched));
  assign mem_read = selected & ~MEM_READ_STROBE_B & ~io_latched;
  assign write_now = selected & ~PORT_WRITE_STROBE_B;
  assign write_release = write_d & PORT_WRITE_STROBE_B;

  always_comb begin
    next_strobe_d = ADDR_STROBE;
    next_low_addr = low_addr;
    next_upper_addr = upper_addr;
    next_io_latched = io_latched;
    next_selected = selected;
    if (strobe_fall) begin
      next_low_addr = MUXED_BUS_LINES_IN;
      next_upper_addr = UPPER_ROM_LINES;
      next_io_latched = IO_SPACE;
      next_selected = enables_live;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      strobe_d <= 1'b0;
      low_addr <= 8'h00;
      upper_addr <= 3'h0;
      io_latched <= 1'b0;
      selected <= 1'b0;
    end else if (CLK_EN) begin
      strobe_d <= next_strobe_d;
      low_addr <= next_low_addr;
      upper_addr <= next_upper_addr;
      io_latched <= next_io_latched;
      selected <= next_selected;
    end
  end

  // A data write is remembered until its strobe rises, then the pins move
  always_comb begin
    next_write_d = write_now;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      write_d <= 1'b0;
    end else if (CLK_EN) begin
      write_d <= next_write_d;
    end
  end

  // Wait is held for the strobe-high cycle and dropped at the next edge
  always_comb begin
    next_wait_active = ADDR_STROBE & enables_live;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      wait_active <= 1'b0;
    end else if (CLK_EN) begin
      wait_active <= next_wait_active;
    end
  end

  assign WAIT_OUT = 1'b0;
  assign WAIT_OE = wait_active;

  rom_array u_rom (
    .clk(CLK),
    .ce(CLK_EN),
    .addr({upper_addr, low_addr}),
    .rdata(rom_data)
  );

  port_bit_group u_first (
    .clk(CLK),
    .rst_b(RST_B),
    .ce(CLK_EN),
    .reset_in(RESET),
    .data_wr(write_now && sel == SEL_FIRST_PORT_DATA),
    .dir_wr(write_now && sel == SEL_FIRST_PORT_DIRECTION),
    .strobe_release(write_release),
    .wdata(MUXED_BUS_LINES_IN),
    .pin_in(FIRST_PORT_PINS_IN),
    .pin_out(FIRST_PORT_PINS_OUT),
    .pin_oe(FIRST_PORT_PINS_OE),
    .read_value(first_read)
  );

  port_bit_group u_second (
    .clk(CLK),
    .rst_b(RST_B),
    .ce(CLK_EN),
    .reset_in(RESET),
    .data_wr(write_now && sel == SEL_SECOND_PORT_DATA),
    .dir_wr(write_now && sel == SEL_SECOND_PORT_DIRECTION),
    .strobe_release(write_release),
    .wdata(MUXED_BUS_LINES_IN),
    .pin_in(SECOND_PORT_PINS_IN),
    .pin_out(SECOND_PORT_PINS_OUT),
    .pin_oe(SECOND_PORT_PINS_OE),
    .read_value(second_read)
  );

  // Direction selections read as zero; upper address plays no part here
  always_comb begin
    unique case (sel)
      SEL_FIRST_PORT_DATA: port_read = first_read;
      SEL_SECOND_PORT_DATA: port_read = second_read;
      default: port_read = 8'h00;
    endcase
  end

  always_comb begin
    next_drive_bus = io_read | mem_read;
    next_read_data = read_data;
    if (io_read) begin
      next_read_data = port_read;
    end
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      drive_bus <= 1'b0;
      read_data <= 8'h00;
    end else if (CLK_EN) begin
      drive_bus <= next_drive_bus;
      read_data <= next_read_data;
    end
  end

  // ROM data come from the array register, port data from read_data
  assign MUXED_BUS_LINES_OUT = io_latched | ~PORT_READ_STROBE_B ? read_data : rom_data;
  assign MUXED_BUS_LINES_OE = drive_bus & selected;
endmodule : rom_io_port

/* File: rtl/rom_port_pkg.sv */
// Package of constants for the ROM and I/O bus port
package rom_port_pkg;
  localparam int DATA_W = 8;
  localparam int ROM_ADDR_W = 11;
  localparam int ROM_DEPTH = 2048;
  localparam int UPPER_W = 3;
  localparam int SEL_W = 2;
  localparam logic [1:0] SEL_FIRST_PORT_DATA = 2'h0;
  localparam logic [1:0] SEL_SECOND_PORT_DATA = 2'h1;
  localparam logic [1:0] SEL_FIRST_PORT_DIRECTION = 2'h2;
  localparam logic [1:0] SEL_SECOND_PORT_DIRECTION = 2'h3;
  localparam logic [7:0] DIRECTION_RESET = 8'h00;
  localparam logic [7:0] LATCH_RESET = 8'h00;
endpackage : rom_port_pkg

/* File: rtl/rom_array.sv */
// ROM array with registered read data
`timescale 1ns/1ps
module rom_array
  import rom_port_pkg::*;
(
  input wire logic clk,
  input wire logic ce,
  input wire logic [ROM_ADDR_W-1:0] addr,
  output logic [DATA_W-1:0] rdata
);
  // Contents default to the erased state; load by a memory image at integration
  logic [DATA_W-1:0] mem [ROM_DEPTH];

  initial begin
    for (int i = 0; i < ROM_DEPTH; i++) begin
      mem[i] = 8'hFF;
    end
  end

  always_ff @(posedge clk) begin
    if (ce) begin
      rdata <= mem[addr];
    end
  end
endmodule : rom_array

/* File: rtl/port_bit_group.sv */
// One 8-bit I/O port: output latch, direction, pin drive
`timescale 1ns/1ps
module port_bit_group
  import rom_port_pkg::*;
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic reset_in,
  input wire logic data_wr,
  input wire logic dir_wr,
  input wire logic strobe_release,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic [DATA_W-1:0] pin_in,
  output logic [DATA_W-1:0] pin_out,
  output logic [DATA_W-1:0] pin_oe,
  output logic [DATA_W-1:0] read_value
);
  logic [DATA_W-1:0] out_latch;
  logic [DATA_W-1:0] staged;
  logic [DATA_W-1:0] direction;
  logic [DATA_W-1:0] next_out_latch;
  logic [DATA_W-1:0] next_staged;
  logic [DATA_W-1:0] next_direction;

  always_comb begin
    next_staged = staged;
    next_out_latch = out_latch;
    next_direction = direction;
    if (data_wr) begin
      next_staged = wdata;
    end
    if (strobe_release) begin
      next_out_latch = staged;
    end
    if (dir_wr) begin
      next_direction = wdata;
    end
    if (reset_in) begin
      next_direction = DIRECTION_RESET;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      out_latch <= LATCH_RESET;
      staged <= LATCH_RESET;
      direction <= DIRECTION_RESET;
    end else if (ce) begin
      out_latch <= next_out_latch;
      staged <= next_staged;
      direction <= next_direction;
    end
  end

  assign pin_out = out_latch;
  assign pin_oe = direction;
  // Output bits read back the latch as driven; input bits read the pin
  assign read_value = (direction & out_latch) | (~direction & pin_in);
endmodule : port_bit_group

/* File: tb/rom_io_port_asserts.sv */
// Timing checker for the ROM and I/O bus port
`timescale 1ns/1ps
module rom_io_port_asserts
  import rom_port_pkg::*;
(
  input wire logic CLK,
  input wire logic RST_B,
  input wire logic RESET,
  input wire logic ADDR_STROBE,
  input wire logic ENABLE_LOW_INPUT_B,
  input wire logic ENABLE_HIGH_INPUT,
  input wire logic MEM_READ_STROBE_B,
  input wire logic PORT_READ_STROBE_B,
  input wire logic PORT_WRITE_STROBE_B,
  input wire logic MUXED_BUS_LINES_OE,
  input wire logic WAIT_OUT,
  input wire logic WAIT_OE,
  input wire logic [DATA_W-1:0] FIRST_PORT_PINS_OUT,
  input wire logic [DATA_W-1:0] FIRST_PORT_PINS_OE,
  input wire logic [DATA_W-1:0] SECOND_PORT_PINS_OUT,
  input wire logic [DATA_W-1:0] SECOND_PORT_PINS_OE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  logic live;
  assign live = !ENABLE_LOW_INPUT_B && ENABLE_HIGH_INPUT;
  property p_wait_rise; ADDR_STROBE && live |=> WAIT_OE && !WAIT_OUT; endproperty
  a_wait_rise: assert property (p_wait_rise) else $error("wait not driven");
  property p_wait_fall; $fell(ADDR_STROBE) |=> !WAIT_OE; endproperty
  a_wait_fall: assert property (p_wait_fall) else $error("wait not floated");
  property p_wait_cause; WAIT_OE |-> $past(ADDR_STROBE && live); endproperty
  a_wait_cause: assert property (p_wait_cause) else $error("wait without enables");
  property p_float; MEM_READ_STROBE_B && PORT_READ_STROBE_B |=> !MUXED_BUS_LINES_OE; endproperty
  a_float: assert property (p_float) else $error("bus driven without read");
  property p_oe_cause; MUXED_BUS_LINES_OE |-> $past(!MEM_READ_STROBE_B || !PORT_READ_STROBE_B);
  endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("bus drive without strobe");
  property p_glitch;
    !PORT_WRITE_STROBE_B |=> $stable(FIRST_PORT_PINS_OUT) && $stable(SECOND_PORT_PINS_OUT);
  endproperty
  a_glitch: assert property (p_glitch) else $error("pins moved during write");
  property p_dir_reset; RESET |=> (FIRST_PORT_PINS_OE | SECOND_PORT_PINS_OE) == 8'h00; endproperty
  a_dir_reset: assert property (p_dir_reset) else $error("direction not cleared");
  property p_dir_cause;
    ($changed(FIRST_PORT_PINS_OE) || $changed(SECOND_PORT_PINS_OE)) && !$past(RESET)
      |-> $past(!PORT_WRITE_STROBE_B);
  endproperty
  a_dir_cause: assert property (p_dir_cause) else $error("direction moved without write");
  c_write: cover property (!PORT_WRITE_STROBE_B ##1 PORT_WRITE_STROBE_B);
  c_read: cover property (!MEM_READ_STROBE_B ##1 MUXED_BUS_LINES_OE);
  c_wait: cover property (WAIT_OE ##1 !WAIT_OE);
endmodule : rom_io_port_asserts
bind rom_io_port rom_io_port_asserts u_chk (.*);

/* File: tb/host_bus_model.sv */
// Host processor model for the multiplexed bus
`timescale 1ns/1ps
module host_bus_model
  import rom_port_pkg::*;
(
  input wire logic CLK,
  output logic ADDR_STROBE,
  output logic [DATA_W-1:0] MUXED_BUS_LINES_IN,
  output logic [UPPER_W-1:0] UPPER_ROM_LINES,
  output logic IO_SPACE,
  output logic ENABLE_LOW_INPUT_B,
  output logic ENABLE_HIGH_INPUT,
  output logic MEM_READ_STROBE_B,
  output logic PORT_READ_STROBE_B,
  output logic PORT_WRITE_STROBE_B
);
  initial begin
    {ADDR_STROBE, UPPER_ROM_LINES, MUXED_BUS_LINES_IN, IO_SPACE} = 13'h0000;
    {ENABLE_LOW_INPUT_B, ENABLE_HIGH_INPUT} = 2'b10;
    {MEM_READ_STROBE_B, PORT_READ_STROBE_B, PORT_WRITE_STROBE_B} = 3'b111;
  end
  // Kind 0 memory read, 1 port read, 2 port write
  task cycle(input logic [10:0] a, input logic io, en, input logic [1:0] kind,
             input logic [7:0] d);
    @(negedge CLK);
    {ADDR_STROBE, UPPER_ROM_LINES, MUXED_BUS_LINES_IN} = {1'b1, a};
    {IO_SPACE, ENABLE_LOW_INPUT_B, ENABLE_HIGH_INPUT} = {io, !en, en};
    @(negedge CLK);
    ADDR_STROBE = 1'b0;
    @(negedge CLK);
    // Latched values must win, so the lines flip once held long enough
    {IO_SPACE, ENABLE_LOW_INPUT_B, ENABLE_HIGH_INPUT, UPPER_ROM_LINES} = ~{io, !en, en, a[10:8]};
    MUXED_BUS_LINES_IN = (kind == 2'd2) ? d : ~a[7:0];
    MEM_READ_STROBE_B = kind != 2'd0;
    PORT_READ_STROBE_B = kind != 2'd1;
    PORT_WRITE_STROBE_B = kind != 2'd2;
    repeat (2) @(negedge CLK);
    {MEM_READ_STROBE_B, PORT_READ_STROBE_B, PORT_WRITE_STROBE_B} = 3'b111;
    MUXED_BUS_LINES_IN = ~MUXED_BUS_LINES_IN;
    @(negedge CLK);
  endtask : cycle
endmodule : host_bus_model

/* File: tb/tb_top.sv */
// Self-checking bench for the ROM and I/O bus port
`timescale 1ns/1ps
module tb_top
  import rom_port_pkg::*;
;
  logic CLK, RST_B, CLK_EN, RESET, ADDR_STROBE, IO_SPACE, ENABLE_LOW_INPUT_B, ENABLE_HIGH_INPUT;
  logic MEM_READ_STROBE_B, PORT_READ_STROBE_B, PORT_WRITE_STROBE_B, MUXED_BUS_LINES_OE;
  logic WAIT_OUT, WAIT_OE, oe_q;
  logic [DATA_W-1:0] MUXED_BUS_LINES_IN, MUXED_BUS_LINES_OUT, ext_a, ext_b, v, m;
  logic [DATA_W-1:0] FIRST_PORT_PINS_IN, FIRST_PORT_PINS_OUT, FIRST_PORT_PINS_OE;
  logic [DATA_W-1:0] SECOND_PORT_PINS_IN, SECOND_PORT_PINS_OUT, SECOND_PORT_PINS_OE;
  logic [UPPER_W-1:0] UPPER_ROM_LINES;
  logic [7:0] exp_q[$];
  logic [31:0] seed = 32'h0000_000F;
  int num_errors = 0;
  int checks_done = 0;
  // Pin level: design drives where enabled, outside circuit elsewhere
  assign FIRST_PORT_PINS_IN = (FIRST_PORT_PINS_OE & FIRST_PORT_PINS_OUT)
    | (~FIRST_PORT_PINS_OE & ext_a);
  assign SECOND_PORT_PINS_IN = (SECOND_PORT_PINS_OE & SECOND_PORT_PINS_OUT)
    | (~SECOND_PORT_PINS_OE & ext_b);
  rom_io_port dut (.*);
  host_bus_model host (.*);
  function logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction : rnd
  task check(input string what, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task results();
    if (num_errors == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : results
  initial begin
    CLK = 1'b0;
    forever #10 CLK = ~CLK;
  end
  initial begin
    repeat (5000) @(posedge CLK);
    num_errors++;
    results();
  end
  always @(negedge CLK) begin
    if (MUXED_BUS_LINES_OE === 1'b1 && oe_q !== 1'b1) begin
      if (exp_q.size() == 0) check("unexpected read", 8'h01, 8'h00);
      else check("bus data", MUXED_BUS_LINES_OUT, exp_q.pop_front());
    end
    oe_q = MUXED_BUS_LINES_OE;
  end
  initial begin
    {RST_B, CLK_EN, RESET} = 3'b010;
    ext_a = rnd();
    ext_b = rnd();
    repeat (6) @(negedge CLK);
    RST_B = 1'b1;
    for (int i = 0; i < 4; i++) begin
      v = rnd();
      m = rnd();
      // Distinct bytes per location, so a wrong address shows up
      dut.u_rom.mem[{m[2:0], v}] = v ^ 8'h5A;
      exp_q.push_back(v ^ 8'h5A);
      host.cycle({m[2:0], v}, 1'b0, 1'b1, 2'd0, 8'h00);
    end
    host.cycle(11'h000, 1'b1, 1'b0, 2'd1, 8'h00);
    for (int p = 0; p < 2; p++) begin
      v = rnd();
      m = rnd();
      host.cycle({3'h7, 7'h00, p[0]}, 1'b0, 1'b1, 2'd2, v);
      check("direction", p ? SECOND_PORT_PINS_OE : FIRST_PORT_PINS_OE, 8'h00);
      host.cycle({3'h5, 7'h01, p[0]}, 1'b1, 1'b1, 2'd2, m);
      check("direction", p ? SECOND_PORT_PINS_OE : FIRST_PORT_PINS_OE, m);
      check("latch", p ? SECOND_PORT_PINS_OUT : FIRST_PORT_PINS_OUT, v);
      exp_q.push_back((v & m) | ((p ? ext_b : ext_a) & ~m));
      host.cycle({3'h2, 7'h00, p[0]}, 1'b1, 1'b1, 2'd0, 8'h00);
      exp_q.push_back((v & m) | ((p ? ext_b : ext_a) & ~m));
      host.cycle({3'h6, 7'h00, p[0]}, 1'b0, 1'b1, 2'd1, 8'h00);
      exp_q.push_back(8'h00);
      host.cycle({3'h1, 7'h01, p[0]}, 1'b0, 1'b1, 2'd1, 8'h00);
    end
    RESET = 1'b1;
    @(negedge CLK);
    RESET = 1'b0;
    @(negedge CLK);
    check("reset direction", FIRST_PORT_PINS_OE | SECOND_PORT_PINS_OE, 8'h00);
    repeat (3) @(negedge CLK);
    check("pending reads", 8'(exp_q.size()), 8'h00);
    results();
  end
endmodule : tb_top
